// *** rcr_regs.sv ***
// register bank and apb slave for regulators a and b
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rcr_regs
  import rcr_pkg::*;
#(
  parameter logic [7:0] A_VOLT_DEFAULT = RCR_RST_A_VOLT, // variant default
  parameter logic [7:0] A_ENA_DEFAULT  = RCR_RST_A_ENA,  // variant default
  parameter logic [7:0] B_VOLT_DEFAULT = RCR_RST_B_VOLT, // variant default
  parameter logic [7:0] B_ENA_DEFAULT  = RCR_RST_B_ENA   // variant default
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        standby_state,
  input  wire logic [2:0]  gpin,
  input  wire logic [11:0] reg_a_out_mv,
  input  wire logic [11:0] reg_b_out_mv,
  output logic [4:0]       reg_a_voltage_code,
  output logic             reg_a_switch_mode,
  output logic [1:0]       reg_a_start_phase,
  output logic             reg_a_on,
  output logic [11:0]      reg_a_target_mv,
  output logic [4:0]       reg_b_voltage_code,
  output logic             reg_b_switch_mode,
  output logic [1:0]       reg_b_start_phase,
  output logic             reg_b_on,
  output logic [11:0]      reg_b_target_mv,
  output logic             irq
);

  // number of regulator channels in this bank
  localparam int NCH = 2;

  // address decode helpers

  // true when the byte address hits the word of the given index
  function automatic logic hit(input logic [11:0] addr,
                               input logic [7:0]  idx);
    hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction : hit

  // true when the byte address maps to any register of the bank
  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, RCR_IDX_A_VOLT) | hit(addr, RCR_IDX_A_ENA) |
             hit(addr, RCR_IDX_B_VOLT) | hit(addr, RCR_IDX_B_ENA) |
             hit(addr, RCR_IDX_IRQ_STS) | hit(addr, RCR_IDX_IRQ_MSK);
  endfunction : mapped

  // declarations

  rcr_apb_e     apb_reg;              // apb slave state
  rcr_apb_e     apb_next;             // next apb slave state
  logic [7:0]   volt_reg [NCH];       // voltage and mode registers
  logic [7:0]   ena_reg  [NCH];       // enable registers
  logic [7:0]   volt_idx [NCH];       // register index, voltage
  logic [7:0]   ena_idx  [NCH];       // register index, enable
  logic [11:0]  out_mv   [NCH];       // measured outputs per channel
  logic [11:0]  tgt_mv   [NCH];       // decoded targets per channel
  logic         ch_on    [NCH];       // channel on state
  logic         ch_fail  [NCH];       // channel power fail pulses
  logic [1:0]   irq_sts_reg;          // sticky power fail status
  logic [1:0]   irq_msk_reg;          // interrupt mask, one enables
  logic [1:0]   fail_evt;             // fail pulses gathered
  logic [2:0]   gpin_meta_reg;        // first sync stage of inputs
  logic [2:0]   gpin_sync_reg;        // second sync stage of inputs
  logic         stby_reg;             // previous standby level
  logic         stby_entry;           // rising edge of standby
  logic         wr_ok;                // write taken this edge
  logic         wr_lane0;             // low byte lane is written
  logic [7:0]   wr_byte;              // written byte, live bits only
  logic [31:0]  rd_next;              // read data for the captured word
  logic         setup_phase;          // setup cycle on the bus

  // per channel constants and measured outputs
  assign volt_idx[0] = RCR_IDX_A_VOLT;
  assign ena_idx[0]  = RCR_IDX_A_ENA;
  assign volt_idx[1] = RCR_IDX_B_VOLT;
  assign ena_idx[1]  = RCR_IDX_B_ENA;
  assign out_mv[0]   = reg_a_out_mv;
  assign out_mv[1]   = reg_b_out_mv;

  // input synchronisers and standby entry

  // two stage synchroniser for the general purpose inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpin_meta_reg <= 3'h0;
      gpin_sync_reg <= 3'h0;
    end else begin
      gpin_meta_reg <= gpin;
      gpin_sync_reg <= gpin_meta_reg;
    end
  end

  // standby comes from the same clock, only its edge is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stby_reg <= 1'b0;
    end else begin
      stby_reg <= standby_state;
    end
  end

  // a reload happens once per entry, not while staying in standby
  assign stby_entry = standby_state & ~stby_reg;

  // apb slave sequencing

  // setup cycle: select high, enable still low
  assign setup_phase = psel & ~penable;

  // next state follows the master's phases
  always_comb begin
    case (apb_reg)
      RCR_APB_IDLE: begin
        apb_next = setup_phase ? RCR_APB_SETUP : RCR_APB_IDLE;
      end
      RCR_APB_SETUP: begin
        // access always follows setup
        apb_next = RCR_APB_ACCESS;
      end
      RCR_APB_ACCESS: begin
        // back to back transfers go straight to setup
        apb_next = setup_phase ? RCR_APB_SETUP : RCR_APB_IDLE;
      end
      default: begin
        apb_next = RCR_APB_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_reg <= RCR_APB_IDLE;
    end else begin
      apb_reg <= apb_next;
    end
  end

  // zero wait states: ready in every access cycle
  assign pready = psel & penable;

  // unmapped addresses answer with an error in the access cycle
  assign pslverr = psel & penable & ~mapped(paddr);

  // a write lands at the single edge where the access completes
  assign wr_ok    = psel & penable & pwrite & mapped(paddr);
  assign wr_lane0 = pstrb[0];
  assign wr_byte  = pwdata[7:0] & RCR_LIVE_MASK;

  // regulator registers

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_regs

      // variant defaults of channel i, constant so reset loads no logic
      localparam logic [7:0] VOLT_DEF = (i == 0) ? A_VOLT_DEFAULT : B_VOLT_DEFAULT;
      localparam logic [7:0] ENA_DEF  = (i == 0) ? A_ENA_DEFAULT : B_ENA_DEFAULT;

      // voltage and mode register of channel i
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          volt_reg[i] <= VOLT_DEF & RCR_LIVE_MASK;
        end else if (stby_entry) begin
          // standby entry wins over a write in the same cycle
          volt_reg[i] <= VOLT_DEF & RCR_LIVE_MASK;
        end else if (wr_ok && wr_lane0 && hit(paddr, volt_idx[i])) begin
          volt_reg[i] <= wr_byte;
        end
      end

      // enable register of channel i
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ena_reg[i] <= ENA_DEF & RCR_LIVE_MASK;
        end else if (stby_entry) begin
          ena_reg[i] <= ENA_DEF & RCR_LIVE_MASK;
        end else if (wr_ok && wr_lane0 && hit(paddr, ena_idx[i])) begin
          ena_reg[i] <= wr_byte;
        end
      end

      // on decision, target and power fail check
      rcr_chan u_chan (
        .pclk       (pclk),
        .presetn    (presetn),
        .volt_reg   (volt_reg[i]),
        .ena_reg    (ena_reg[i]),
        .gpin_sync  (gpin_sync_reg),
        .out_mv     (out_mv[i]),
        .enabled    (ch_on[i]),
        .target_mv  (tgt_mv[i]),
        .fail_pulse (ch_fail[i])
      );

      // gather the fail pulse into the status vector
      assign fail_evt[i] = ch_fail[i];

    end
  endgenerate

  // interrupt status and mask

  // sticky status: a new event wins over a write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_reg <= RCR_RST_IRQ;
    end else if (wr_ok && wr_lane0 && hit(paddr, RCR_IDX_IRQ_STS)) begin
      irq_sts_reg <= (irq_sts_reg & ~pwdata[1:0]) | fail_evt;
    end else begin
      irq_sts_reg <= irq_sts_reg | fail_evt;
    end
  end

  // mask register, plain read and write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_msk_reg <= RCR_RST_IRQ;
    end else if (wr_ok && wr_lane0 && hit(paddr, RCR_IDX_IRQ_MSK)) begin
      irq_msk_reg <= pwdata[1:0];
    end
  end

  // level interrupt from the registered status and mask
  assign irq = |(irq_sts_reg & irq_msk_reg);

  // read path

  // read mux, reserved and unmapped bits read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(paddr, RCR_IDX_A_VOLT)) begin
      rd_next[7:0] = volt_reg[0] & RCR_LIVE_MASK;
    end else if (hit(paddr, RCR_IDX_A_ENA)) begin
      rd_next[7:0] = ena_reg[0] & RCR_LIVE_MASK;
    end else if (hit(paddr, RCR_IDX_B_VOLT)) begin
      rd_next[7:0] = volt_reg[1] & RCR_LIVE_MASK;
    end else if (hit(paddr, RCR_IDX_B_ENA)) begin
      rd_next[7:0] = ena_reg[1] & RCR_LIVE_MASK;
    end else if (hit(paddr, RCR_IDX_IRQ_STS)) begin
      rd_next[1:0] = irq_sts_reg;
    end else if (hit(paddr, RCR_IDX_IRQ_MSK)) begin
      rd_next[1:0] = irq_msk_reg;
    end
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= rd_next;
    end
  end

  // regulator control outputs

  // register fields driven out to the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_a_voltage_code <= 5'h00;
      reg_a_switch_mode  <= 1'b0;
      reg_a_start_phase  <= START_PHASE_ONE;
      reg_b_voltage_code <= 5'h00;
      reg_b_switch_mode  <= 1'b0;
      reg_b_start_phase  <= START_PHASE_ONE;
    end else begin
      reg_a_voltage_code <= volt_reg[0][RCR_VOLT_CODE_MSB:RCR_VOLT_CODE_LSB];
      reg_a_switch_mode  <= volt_reg[0][RCR_SWITCH_BIT];
      reg_a_start_phase  <= ena_reg[0][RCR_PHASE_MSB:RCR_PHASE_LSB];
      reg_b_voltage_code <= volt_reg[1][RCR_VOLT_CODE_MSB:RCR_VOLT_CODE_LSB];
      reg_b_switch_mode  <= volt_reg[1][RCR_SWITCH_BIT];
      reg_b_start_phase  <= ena_reg[1][RCR_PHASE_MSB:RCR_PHASE_LSB];
    end
  end

  // on state and targets come registered from the channels
  assign reg_a_on        = ch_on[0];
  assign reg_b_on        = ch_on[1];
  assign reg_a_target_mv = tgt_mv[0];
  assign reg_b_target_mv = tgt_mv[1];

endmodule : rcr_regs
`default_nettype wire

// *** rcr_pkg.sv ***
// constants and types for the regulator control register bank
// Summary of operation
// - code sets 0.9 V plus 0.1 V steps, capped 3.6 V
// - bit 5 chooses linear or switch mode
// - on bit, or gated bit with matching input high
// - bits 5:4 pick start phase one to four
// - every regulator register reloads default entering Standby
// - regulator A registers at 2Dh and 2Eh
// - regulator B registers at 2Fh and 30h
// - output under ninety percent target raises fail event, only while the regulator is on
package rcr_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [7:0] RCR_IDX_A_VOLT  = 8'h2D;
  localparam logic [7:0] RCR_IDX_A_ENA   = 8'h2E;
  localparam logic [7:0] RCR_IDX_B_VOLT  = 8'h2F;
  localparam logic [7:0] RCR_IDX_B_ENA   = 8'h30;
  localparam logic [7:0] RCR_IDX_IRQ_STS = 8'h38;
  localparam logic [7:0] RCR_IDX_IRQ_MSK = 8'h39;

  // field positions of the voltage and mode register
  localparam int RCR_VOLT_CODE_LSB = 0;
  localparam int RCR_VOLT_CODE_MSB = 4;
  localparam int RCR_SWITCH_BIT    = 5;

  // field positions of the enable register
  localparam int RCR_FORCE_ON_BIT  = 0;
  localparam int RCR_GPIN_LSB      = 1;
  localparam int RCR_GPIN_MSB      = 3;
  localparam int RCR_PHASE_LSB     = 4;
  localparam int RCR_PHASE_MSB     = 5;

  // writable bits of the four regulator registers, 7:6 reserved
  localparam logic [7:0] RCR_LIVE_MASK = 8'h3F;

  // default values, the four regulator ones overridden per chip variant
  localparam logic [7:0] RCR_RST_A_VOLT = 8'h00;
  localparam logic [7:0] RCR_RST_A_ENA  = 8'h00;
  localparam logic [7:0] RCR_RST_B_VOLT = 8'h00;
  localparam logic [7:0] RCR_RST_B_ENA  = 8'h00;
  localparam logic [1:0] RCR_RST_IRQ    = 2'h0;

  // voltage decode in millivolts
  localparam logic [11:0] RCR_BASE_MV  = 12'h384;
  localparam logic [11:0] RCR_STEP_MV  = 12'h064;
  localparam logic [11:0] RCR_MAX_MV   = 12'hE10;
  localparam logic [4:0]  RCR_MAX_CODE = 5'h1B;

  // power fail threshold as a ratio, nine tenths
  localparam logic [3:0] RCR_PF_NUM = 4'h9;
  localparam logic [3:0] RCR_PF_DEN = 4'hA;

  // activation phase encodings
  typedef enum logic [1:0] {
    START_PHASE_ONE   = 2'b00,
    START_PHASE_TWO   = 2'b01,
    START_PHASE_THREE = 2'b10,
    START_PHASE_FOUR  = 2'b11
  } rcr_phase_e;

  // apb slave states, gray along idle, setup, access
  typedef enum logic [1:0] {
    RCR_APB_IDLE   = 2'b00,
    RCR_APB_SETUP  = 2'b01,
    RCR_APB_ACCESS = 2'b11
  } rcr_apb_e;

endpackage : rcr_pkg

// *** rcr_chan.sv ***
// one regulator channel: on decision, target voltage and power fail check
`timescale 1ns/1ps
`default_nettype none
module rcr_chan
  import rcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  volt_reg,
  input  wire logic [7:0]  ena_reg,
  input  wire logic [2:0]  gpin_sync,
  input  wire logic [11:0] out_mv,
  output logic             enabled,
  output logic [11:0]      target_mv,
  output logic             fail_pulse
);

  logic [4:0]  code;         // programmed voltage code
  logic [11:0] target_next;  // decoded target
  logic        on_next;      // combined on condition
  logic        low_now;      // output under threshold now
  logic        low_reg;      // previous low state
  logic [15:0] out_x10;      // measured times ten
  logic [15:0] tgt_x9;       // target times nine

  assign code = volt_reg[RCR_VOLT_CODE_MSB:RCR_VOLT_CODE_LSB];

  // decode code to millivolts, saturating above the top step
  always_comb begin
    if (code > RCR_MAX_CODE) begin
      target_next = RCR_MAX_MV;
    end else begin
      target_next = 12'(RCR_BASE_MV + 12'(code) * RCR_STEP_MV);
    end
  end

  // on bit or any gated bit whose input is high
  assign on_next = ena_reg[RCR_FORCE_ON_BIT] |
                   (|(ena_reg[RCR_GPIN_MSB:RCR_GPIN_LSB] & gpin_sync));

  // compare output against nine tenths of the target
  assign out_x10 = 16'(out_mv) * 16'(RCR_PF_DEN);
  assign tgt_x9  = 16'(target_next) * 16'(RCR_PF_NUM);
  assign low_now = on_next && (out_x10 < tgt_x9);

  // registered channel outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled   <= 1'b0;
      target_mv <= 12'h000;
    end else begin
      enabled   <= on_next;
      target_mv <= target_next;
    end
  end

  // one pulse when the output first drops below threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_reg    <= 1'b0;
      fail_pulse <= 1'b0;
    end else begin
      low_reg    <= low_now;
      fail_pulse <= low_now & ~low_reg;
    end
  end

endmodule : rcr_chan
`default_nettype wire

// *** rcr_regs_props.sv ***
// checker module and bind for the regulator control register bank
`timescale 1ns/1ps
`default_nettype none
module rcr_regs_props
  import rcr_pkg::*;
#(
  parameter logic [7:0] A_VOLT_DEFAULT = RCR_RST_A_VOLT, // variant default
  parameter logic [7:0] A_ENA_DEFAULT  = RCR_RST_A_ENA,  // variant default
  parameter logic [7:0] B_VOLT_DEFAULT = RCR_RST_B_VOLT, // variant default
  parameter logic [7:0] B_ENA_DEFAULT  = RCR_RST_B_ENA   // variant default
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        standby_state,
  input wire logic [4:0]  reg_a_voltage_code,
  input wire logic        reg_a_switch_mode,
  input wire logic [1:0]  reg_a_start_phase,
  input wire logic [11:0] reg_a_target_mv,
  input wire logic [4:0]  reg_b_voltage_code,
  input wire logic        reg_b_switch_mode,
  input wire logic [1:0]  reg_b_start_phase
);
  logic       acc;      // access cycle of a transfer
  logic       wr;       // write with lane zero strobed, outside standby
  logic       mapped;   // address hits a bank register
  logic [5:0] a_volt_q; // last accepted regulator a voltage write
  logic [5:0] a_ena_q;  // last accepted regulator a enable write
  logic [5:0] b_volt_q; // last accepted regulator b voltage write

  assign acc    = psel & penable;
  assign wr     = acc & pwrite & pstrb[0] & ~standby_state;
  assign mapped = paddr inside {12'h0B4, 12'h0B8, 12'h0BC, 12'h0C0, 12'h0E0, 12'h0E4};

  // target in millivolts for a code, capped at the top step
  function automatic logic [11:0] mv(input logic [4:0] c);
    return (c > 5'h1B) ? 12'hE10 : 12'h384 + 12'h064 * {7'h00, c};
  endfunction : mv

  // remember the fields of each accepted write to 0B4h, 0B8h and 0BCh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_volt_q <= 6'h00;
      a_ena_q  <= 6'h00;
      b_volt_q <= 6'h00;
    end else if (wr) begin
      if (paddr == 12'h0B4) a_volt_q <= pwdata[5:0];
      if (paddr == 12'h0B8) a_ena_q <= pwdata[5:0];
      if (paddr == 12'h0BC) b_volt_q <= pwdata[5:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_zero_wait;
    acc |-> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready low in access");
  property p_rsvd_zero;
    acc && !pwrite |-> prdata[31:6] == 26'h000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
  property p_unmapped;
    acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_mapped;
    acc && mapped |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_a_volt;
    wr && paddr == 12'h0B4 |-> ##[1:2]
      (reg_a_voltage_code == a_volt_q[4:0] && reg_a_switch_mode == a_volt_q[5]);
  endproperty
  a_a_volt: assert property (p_a_volt) else $error("regulator a fields wrong");
  property p_a_target;
    wr && paddr == 12'h0B4 |-> ##[2:3] reg_a_target_mv == mv(a_volt_q[4:0]);
  endproperty
  a_a_target: assert property (p_a_target) else $error("regulator a target wrong");
  property p_a_phase;
    wr && paddr == 12'h0B8 |-> ##[1:2] reg_a_start_phase == a_ena_q[5:4];
  endproperty
  a_a_phase: assert property (p_a_phase) else $error("regulator a phase wrong");
  property p_b_volt;
    wr && paddr == 12'h0BC |-> ##[1:2]
      (reg_b_voltage_code == b_volt_q[4:0] && reg_b_switch_mode == b_volt_q[5]);
  endproperty
  a_b_volt: assert property (p_b_volt) else $error("regulator b fields wrong");
  property p_standby;
    $rose(standby_state) |-> ##[1:3]
      (reg_a_voltage_code == A_VOLT_DEFAULT[4:0] && reg_a_start_phase == A_ENA_DEFAULT[5:4]
       && reg_b_voltage_code == B_VOLT_DEFAULT[4:0] && reg_b_start_phase == B_ENA_DEFAULT[5:4]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby reload missing");
endmodule : rcr_regs_props

bind rcr_regs rcr_regs_props #(
  .A_VOLT_DEFAULT(A_VOLT_DEFAULT), .A_ENA_DEFAULT(A_ENA_DEFAULT),
  .B_VOLT_DEFAULT(B_VOLT_DEFAULT), .B_ENA_DEFAULT(B_ENA_DEFAULT)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .standby_state(standby_state),
  .reg_a_voltage_code(reg_a_voltage_code), .reg_a_switch_mode(reg_a_switch_mode),
  .reg_a_start_phase(reg_a_start_phase), .reg_a_target_mv(reg_a_target_mv),
  .reg_b_voltage_code(reg_b_voltage_code), .reg_b_switch_mode(reg_b_switch_mode),
  .reg_b_start_phase(reg_b_start_phase)
);
`default_nettype wire

// *** rcr_regs_test.sv ***
// self-checking bench for the regulator control register bank
`timescale 1ns/1ps
`default_nettype none
module rcr_regs_test import rcr_pkg::*;;
  // variant defaults, reserved bits set in all but BED
  localparam logic [7:0] AVD = 8'hE5;
  localparam logic [7:0] AED = 8'hF1;
  localparam logic [7:0] BVD = 8'h5C;
  localparam logic [7:0] BED = 8'h20;
  // one table row: address, write data, read back, refusal
  typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] q; logic e;} rcr_row_s;
  rcr_row_s rows [6] = '{'{12'h0B4, 8'hFF, 8'h3F, 1'b0}, '{12'h0B8, 8'h5A, 8'h1A, 1'b0},
    '{12'h0BC, 8'hC7, 8'h07, 1'b0}, '{12'h0C0, 8'h3C, 8'h3C, 1'b0},
    '{12'h0C4, 8'h55, 8'h00, 1'b1}, '{12'h02D, 8'h11, 8'h00, 1'b1}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, standby_state, irq;
  logic [11:0] paddr, reg_a_out_mv, reg_b_out_mv, reg_a_target_mv, reg_b_target_mv;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  gpin;
  logic [4:0]  reg_a_voltage_code, reg_b_voltage_code;
  logic [1:0]  reg_a_start_phase, reg_b_start_phase;
  logic        reg_a_switch_mode, reg_b_switch_mode, reg_a_on, reg_b_on, er;
  int          num_errors, checks, c;

  rcr_regs #(.A_VOLT_DEFAULT(AVD), .A_ENA_DEFAULT(AED), .B_VOLT_DEFAULT(BVD),
    .B_ENA_DEFAULT(BED)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby_state(standby_state),
    .gpin(gpin), .reg_a_out_mv(reg_a_out_mv), .reg_b_out_mv(reg_b_out_mv),
    .reg_a_voltage_code(reg_a_voltage_code), .reg_a_switch_mode(reg_a_switch_mode),
    .reg_a_start_phase(reg_a_start_phase), .reg_a_on(reg_a_on),
    .reg_a_target_mv(reg_a_target_mv), .reg_b_voltage_code(reg_b_voltage_code),
    .reg_b_switch_mode(reg_b_switch_mode), .reg_b_start_phase(reg_b_start_phase),
    .reg_b_on(reg_b_on), .reg_b_target_mv(reg_b_target_mv), .irq(irq));

  // verdict and end of run
  task automatic end_of_test;
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // compare one value and report a mismatch
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; read data to rd, refusal to er
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, {31'h0, pready});
      end_of_test();
    end
  endtask : apb

  // read all four registers against the variant defaults
  task automatic chk_defaults;
    apb(1'b0, 12'h0B4, 8'h00, 4'hF);
    chk("a_volt", {24'h00_0000, AVD & 8'h3F}, rd);
    apb(1'b0, 12'h0B8, 8'h00, 4'hF);
    chk("a_ena", {24'h00_0000, AED & 8'h3F}, rd);
    apb(1'b0, 12'h0BC, 8'h00, 4'hF);
    chk("b_volt", {24'h00_0000, BVD & 8'h3F}, rd);
    apb(1'b0, 12'h0C0, 8'h00, 4'hF);
    chk("b_ena", {24'h00_0000, BED & 8'h3F}, rd);
  endtask : chk_defaults

  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    {psel, penable, pwrite, standby_state, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    gpin = 3'h0;
    reg_a_out_mv = 12'hFFF;
    reg_b_out_mv = 12'hFFF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk_defaults();
    // table of writes and read-backs
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, 4'hF);
      apb(1'b0, rows[i].a, 8'h00, 4'hF);
      chk("prdata", {24'h00_0000, rows[i].q}, rd);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
    end
    // every voltage code, switch bit toggling
    for (c = 0; c < 32; c++) begin
      apb(1'b1, 12'h0B4, {2'b11, 1'(c), 5'(c)}, 4'hF);
      repeat (4) @(posedge pclk);
      chk("target", (c > 27) ? 32'h0000_0E10 : 32'h0000_0384 + 32'h0000_0064 * c,
          {20'h0_0000, reg_a_target_mv});
      chk("mode", {31'h0, 1'(c)}, {31'h0, reg_a_switch_mode});
    end
    // byte lane zero off: write ignored
    apb(1'b1, 12'h0B4, 8'h2A, 4'hE);
    apb(1'b0, 12'h0B4, 8'h00, 4'hF);
    chk("strobe", 32'h0000_003F, rd);
    // all four start phases on both regulators
    for (c = 0; c < 4; c++) begin
      apb(1'b1, 12'h0B8, 8'(c << 4), 4'hF);
      apb(1'b1, 12'h0C0, 8'((3 - c) << 4), 4'hF);
      repeat (4) @(posedge pclk);
      chk("phase_a", 32'(c), {30'h0, reg_a_start_phase});
      chk("phase_b", 32'(3 - c), {30'h0, reg_b_start_phase});
    end
    // each input-gated on bit, other inputs high then its own
    for (c = 0; c < 3; c++) begin
      apb(1'b1, 12'h0B8, 8'(2 << c), 4'hF);
      apb(1'b1, 12'h0C0, 8'(2 << c), 4'hF);
      gpin <= 3'(7 ^ (1 << c));
      repeat (6) @(posedge pclk);
      chk("on_off", 32'h0000_0000, {30'h0, reg_a_on, reg_b_on});
      gpin <= 3'(1 << c);
      repeat (6) @(posedge pclk);
      chk("on_gated", 32'h0000_0003, {30'h0, reg_a_on, reg_b_on});
    end
    gpin <= 3'h0;
    apb(1'b1, 12'h0B8, 8'h01, 4'hF);
    repeat (6) @(posedge pclk);
    chk("on_force", 32'h0000_0001, {31'h0, reg_a_on});
    // fail at ninety percent of 3300 mV, unmasked
    apb(1'b1, 12'h0E4, 8'h03, 4'hF);
    apb(1'b1, 12'h0B4, 8'h18, 4'hF);
    reg_a_out_mv <= 12'hB9A;
    repeat (6) @(posedge pclk);
    chk("irq_edge", 32'h0000_0000, {31'h0, irq});
    reg_a_out_mv <= 12'hB99;
    c = 0;
    while (irq !== 1'b1 && c < 20) begin
      @(posedge pclk);
      c++;
    end
    chk("irq_set", 32'h0000_0001, {31'h0, irq});
    if (c == 20) end_of_test();
    apb(1'b0, 12'h0E0, 8'h00, 4'hF);
    chk("status_a", 32'h0000_0001, rd);
    apb(1'b1, 12'h0E0, 8'h01, 4'hF);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0000_0000, {31'h0, irq});
    // masked fail on regulator b at 900 mV, unmask, clear
    apb(1'b1, 12'h0E4, 8'h01, 4'hF);
    apb(1'b1, 12'h0BC, 8'h00, 4'hF);
    apb(1'b1, 12'h0C0, 8'h01, 4'hF);
    reg_b_out_mv <= 12'h329;
    repeat (6) @(posedge pclk);
    chk("irq_mask", 32'h0000_0000, {31'h0, irq});
    chk("target_b", 32'h0000_0384, {20'h0_0000, reg_b_target_mv});
    apb(1'b0, 12'h0E0, 8'h00, 4'hF);
    chk("status_b", 32'h0000_0002, rd);
    apb(1'b1, 12'h0E4, 8'h03, 4'hF);
    repeat (2) @(posedge pclk);
    chk("irq_unmask", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, 12'h0E0, 8'h02, 4'hF);
    apb(1'b0, 12'h0E0, 8'h00, 4'hF);
    chk("status_clr", 32'h0000_0000, rd);
    reg_a_out_mv <= 12'hFFF;
    reg_b_out_mv <= 12'hFFF;
    // standby entry reloads the defaults
    repeat (3) @(posedge pclk);
    standby_state <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("code_a", {27'h0, AVD[4:0]}, {27'h0, reg_a_voltage_code});
    chk("code_b", {27'h0, BVD[4:0]}, {27'h0, reg_b_voltage_code});
    chk_defaults();
    standby_state <= 1'b0;
    // second reset in mid-run
    apb(1'b1, 12'h0BC, 8'h11, 4'hF);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_defaults();
    end_of_test();
  end
endmodule : rcr_regs_test
`default_nettype wire
